/* File: logic/lco_pkg.sv */
// Constants, encodings and timing for the logical complement/OR datapath
package lco_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // Word and accumulator geometry
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ACC_W    = 36;
  localparam int unsigned ACC_MID_LO = 16;
  localparam int unsigned ACC_MID_HI = 31;
  localparam int unsigned SHORT_W  = 6;

  // Condition code positions in the status word
  localparam int unsigned CC_C = 0;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_N = 3;

  // Masks and bases
  localparam logic [15:0] MASK_ALL  = 16'hffff;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] IO_BASE   = 16'hffc0;
  localparam logic [9:0]  SHORT_PAD = 10'h000;

  // Cycle and word counts per form
  localparam logic [2:0] CYC_OR    = 3'h2;
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG  = 3'h6;
  localparam logic [1:0] WRD_ONE   = 2'h1;
  localparam logic [1:0] WRD_TWO   = 2'h2;
  localparam logic [1:0] WRD_THREE = 2'h3;

  // Stage counts inside a transfer
  localparam logic [2:0] CNT_FIRST = 3'h1;
  localparam logic [2:0] CNT_ONE   = 3'h1;

  typedef enum logic [2:0] {
    LCO_OP_COMPL_CARRY = 3'h0, // complement_with_carry_op
    LCO_OP_IMM_SET     = 3'h1, // immediate_mask_set_op
    LCO_OP_REG_OR      = 3'h2,
    LCO_OP_BF_CHANGE   = 3'h3, // bitfield_change_op
    LCO_OP_BF_SET      = 3'h4  // bitfield_set_op
  } lco_op_t;

  typedef enum logic [2:0] {
    LCO_FORM_REG     = 3'h0, // any_register_operand
    LCO_FORM_R2_OFF  = 3'h1, // address_reg_two plus offset
    LCO_FORM_SP_OFF  = 3'h2, // stack_pointer minus offset
    LCO_FORM_SHORT   = 3'h3,
    LCO_FORM_IO      = 3'h4,
    LCO_FORM_LONG    = 3'h5
  } lco_form_t;

  typedef enum logic [2:0] {
    LCO_DST_REG16  = 3'h0,
    LCO_DST_ACC    = 3'h1,
    LCO_DST_STATUS = 3'h2, // status_word
    LCO_DST_HWS    = 3'h3  // hardware_stack
  } lco_dst_t;

  typedef enum logic [2:0] {
    LCO_ST_IDLE = 3'b000,
    LCO_ST_RD   = 3'b001,
    LCO_ST_EX   = 3'b011,
    LCO_ST_WB   = 3'b010,
    LCO_ST_HOLD = 3'b110
  } lco_state_t;

endpackage : lco_pkg

/* File: logic/lco_bitfield.sv */
// Bit-field change/set unit with carry test
`timescale 1ns/10ps
module lco_bitfield
  import lco_pkg::*;
(
  input  wire logic        set_mode,
  input  wire logic [15:0] mask,
  input  wire logic [15:0] operand,
  output logic      [15:0] result,
  output logic             carry
);

  // *****************************************************************
  // Bit-field operation
  // *****************************************************************

  // Set mode ORs the mask in, change mode inverts the masked bits
  wire [15:0] set_val    = operand | mask;
  wire [15:0] change_val = operand ^ mask;

  assign result = set_mode ? set_val : change_val;
  // Carry when every masked bit was one before the write-back
  assign carry  = ((operand & mask) == mask);

endmodule // lco_bitfield

/* File: logic/lco_exec.sv */
// Execution unit for complement-with-carry, register OR and immediate OR
`timescale 1ns/10ps
module lco_exec
  import lco_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire lco_op_t     op,
  input  wire lco_form_t   form,
  input  wire lco_dst_t    dst,
  input  wire logic [15:0] imm,
  input  wire logic [15:0] src_val,
  input  wire logic [15:0] reg_val,
  input  wire logic [35:0] acc_val,
  input  wire logic [15:0] sr_val,
  input  wire logic [15:0] addr_reg_two,
  input  wire logic [15:0] stack_pointer,
  input  wire logic [5:0]  short_addr,
  input  wire logic [5:0]  offset,
  input  wire logic [15:0] long_addr,
  input  wire logic [15:0] mem_rdata,
  output logic             busy,
  output logic             done,
  output logic             refused,
  output logic      [1:0]  instr_words,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic             mem_io,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             acc_wr,
  output logic      [35:0] acc_wdata,
  output logic             sr_wr,
  output logic      [15:0] sr_wdata
);

  // *****************************************************************
  // Decode helpers
  // *****************************************************************

  // Cycle count of one instruction by operation and form
  function automatic logic [2:0] cycles_of(lco_op_t o, lco_form_t f);
    logic [2:0] c;
    c = CYC_SHORT;
    if (o == LCO_OP_REG_OR)
      c = CYC_OR;
    else if (f == LCO_FORM_R2_OFF || f == LCO_FORM_SP_OFF
             || f == LCO_FORM_LONG)
      c = CYC_LONG;
    return c;
  endfunction

  // Program words of one instruction by operation and form
  function automatic logic [1:0] words_of(lco_op_t o, lco_form_t f);
    logic [1:0] w;
    w = WRD_TWO;
    if (o == LCO_OP_REG_OR)
      w = WRD_ONE;
    else if (f == LCO_FORM_LONG)
      w = WRD_THREE;
    return w;
  endfunction

  // *****************************************************************
  // Registers
  // *****************************************************************

  lco_state_t  state_ff, nxt_state;
  logic [2:0]  cnt_ff;
  logic [2:0]  last_ff;
  logic        set_mode_ff;
  logic [15:0] mask_ff;
  logic        to_mem_ff;
  lco_dst_t    dst_ff;
  logic [15:0] reg_ff;
  logic [35:0] acc_ff;
  logic [15:0] sr_ff;
  logic [1:0]  words_ff;
  logic        mem_rd_ff, mem_wr_ff, mem_io_ff;
  logic [15:0] mem_addr_ff, mem_wdata_ff;
  logic        reg_wr_ff, acc_wr_ff, sr_wr_ff;
  logic [15:0] reg_wdata_ff, sr_wdata_ff;
  logic [35:0] acc_wdata_ff;

  // *****************************************************************
  // Request decode
  // *****************************************************************

  wire is_reg_or  = (op == LCO_OP_REG_OR);
  wire is_compl   = (op == LCO_OP_COMPL_CARRY) || (op == LCO_OP_BF_CHANGE);
  wire to_mem     = (form != LCO_FORM_REG);
  wire idle       = (state_ff == LCO_ST_IDLE);
  // A stack destination would corrupt the return chain, so it is refused for every operation except register OR
  wire bad_dst    = !is_reg_or && !to_mem && (dst == LCO_DST_HWS);
  wire take       = start && idle && !bad_dst;
  wire take_bf    = take && !is_reg_or;
  wire take_or    = take && is_reg_or;

  // Complement is a change with every mask bit set
  wire [15:0] mask_in = (op == LCO_OP_COMPL_CARRY) ? MASK_ALL : imm;

  // Effective address per memory form
  wire [15:0] short_ea = {SHORT_PAD, short_addr};
  wire [15:0] io_ea    = IO_BASE | {SHORT_PAD, short_addr};
  wire [15:0] r2_ea    = addr_reg_two + {SHORT_PAD, offset};
  wire [15:0] sp_ea    = stack_pointer - {SHORT_PAD, offset};
  wire [15:0] ea       = (form == LCO_FORM_SHORT) ? short_ea :
                         (form == LCO_FORM_IO)    ? io_ea    :
                         (form == LCO_FORM_R2_OFF)? r2_ea    :
                         (form == LCO_FORM_SP_OFF)? sp_ea    : long_addr;

  // *****************************************************************
  // Register OR datapath (single pass)
  // *****************************************************************

  wire [15:0] or_mid    = src_val | acc_val[ACC_MID_HI:ACC_MID_LO];
  wire [15:0] or_word   = src_val | reg_val;
  wire        or_acc    = (dst == LCO_DST_ACC);
  wire [35:0] or_acc_r  = {acc_val[ACC_W-1:ACC_MID_HI+1], or_mid,
                           acc_val[ACC_MID_LO-1:0]};
  wire [15:0] or_flag_w = or_acc ? or_mid : or_word;
  wire [15:0] or_sr;

  // N, Z from the result word (the middle word for the accumulator), V always cleared, C kept
  assign or_sr = {sr_val[WORD_W-1:CC_N+1],
                  or_flag_w[WORD_W-1],
                  (or_flag_w == WORD_ZERO),
                  1'b0,
                  sr_val[CC_C]};

  // *****************************************************************
  // Bit-field datapath (read-modify-write)
  // *****************************************************************

  // Operand of the modify step: memory data or the captured register
  wire [15:0] bf_operand = to_mem_ff ? mem_rdata :
                           (dst_ff == LCO_DST_ACC) ?
                           acc_ff[ACC_MID_HI:ACC_MID_LO] :
                           (dst_ff == LCO_DST_STATUS) ? sr_ff : reg_ff;
  wire [15:0] bf_result;
  wire        bf_carry;

  lco_bitfield u_bitfield (
    .set_mode (set_mode_ff),
    .mask     (mask_ff),
    .operand  (bf_operand),
    .result   (bf_result),
    .carry    (bf_carry)
  );

  // Only carry moves for ordinary destinations
  wire [15:0] bf_sr = {sr_ff[WORD_W-1:CC_C+1], bf_carry};
  wire [35:0] bf_acc = {acc_ff[ACC_W-1:ACC_MID_HI+1], bf_result,
                        acc_ff[ACC_MID_LO-1:0]};
  wire        bf_to_sr  = !to_mem_ff && (dst_ff == LCO_DST_STATUS);
  wire        bf_to_acc = !to_mem_ff && (dst_ff == LCO_DST_ACC);
  wire        bf_to_reg = !to_mem_ff && (dst_ff == LCO_DST_REG16);
  wire        in_ex     = (state_ff == LCO_ST_EX);

  // *****************************************************************
  // Sequencer
  // *****************************************************************

  // Read, modify, write-back, then pad to the documented cycle count
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      LCO_ST_IDLE: if (take_bf) nxt_state = LCO_ST_RD;
                   else if (take_or) nxt_state = LCO_ST_WB;
      LCO_ST_RD:   nxt_state = LCO_ST_EX;
      LCO_ST_EX:   nxt_state = LCO_ST_WB;
      LCO_ST_WB:   nxt_state = (cnt_ff == last_ff) ? LCO_ST_IDLE
                                                   : LCO_ST_HOLD;
      LCO_ST_HOLD: if (cnt_ff == last_ff) nxt_state = LCO_ST_IDLE;
      default:     nxt_state = LCO_ST_IDLE;
    endcase
  end

  assign busy        = !idle;
  assign done        = !idle && (cnt_ff == last_ff);
  assign refused     = start && idle && bad_dst;
  assign instr_words = words_ff;

  // State, cycle counter and captured operands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= LCO_ST_IDLE;
      cnt_ff      <= '0;
      last_ff     <= '0;
      set_mode_ff <= 1'b0;
      mask_ff     <= '0;
      to_mem_ff   <= 1'b0;
      dst_ff      <= LCO_DST_REG16;
      reg_ff      <= '0;
      acc_ff      <= '0;
      sr_ff       <= '0;
      words_ff    <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= take ? CNT_FIRST : (idle ? '0 : cnt_ff + CNT_ONE);
      if (take)
      begin
        last_ff     <= cycles_of(op, form) - CNT_ONE;
        words_ff    <= words_of(op, form);
        set_mode_ff <= !is_compl;
        mask_ff     <= mask_in;
        to_mem_ff   <= to_mem;
        dst_ff      <= dst;
        reg_ff      <= reg_val;
        acc_ff      <= acc_val;
        sr_ff       <= sr_val;
      end
    end
  end

  // Memory strobes: one read, then one write-back of the same address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rd_ff    <= 1'b0;
      mem_wr_ff    <= 1'b0;
      mem_io_ff    <= 1'b0;
      mem_addr_ff  <= '0;
      mem_wdata_ff <= '0;
    end
    else
    begin
      mem_rd_ff <= take_bf && to_mem;
      mem_wr_ff <= in_ex && to_mem_ff;
      if (take_bf)
      begin
        mem_addr_ff <= ea;
        mem_io_ff   <= (form == LCO_FORM_IO);
      end
      if (in_ex)
        mem_wdata_ff <= bf_result;
    end
  end

  // Register, accumulator and status word write-back
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_wr_ff    <= 1'b0;
      acc_wr_ff    <= 1'b0;
      sr_wr_ff     <= 1'b0;
      reg_wdata_ff <= '0;
      acc_wdata_ff <= '0;
      sr_wdata_ff  <= '0;
    end
    else
    begin
      reg_wr_ff <= (take_or && !or_acc) || (in_ex && bf_to_reg);
      acc_wr_ff <= (take_or && or_acc) || (in_ex && bf_to_acc);
      // Status word is rewritten by every instruction here
      sr_wr_ff  <= take_or || in_ex;
      if (take_or)
      begin
        reg_wdata_ff <= or_word;
        acc_wdata_ff <= or_acc_r;
        sr_wdata_ff  <= or_sr;
      end
      else if (in_ex)
      begin
        reg_wdata_ff <= bf_result;
        acc_wdata_ff <= bf_acc;
        // Status destination takes the masked result with no carry recompute; other destinations take bf_sr with the new carry
        sr_wdata_ff  <= bf_to_sr ? bf_result : bf_sr;
      end
    end
  end

  assign mem_rd    = mem_rd_ff;
  assign mem_wr    = mem_wr_ff;
  assign mem_io    = mem_io_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign reg_wr    = reg_wr_ff;
  assign reg_wdata = reg_wdata_ff;
  assign acc_wr    = acc_wr_ff;
  assign acc_wdata = acc_wdata_ff;
  assign sr_wr     = sr_wr_ff;
  assign sr_wdata  = sr_wdata_ff;

endmodule // lco_exec

/* File: verification/lco_exec_checker.sv */
// Concurrent checks on the ports of the complement/OR execution unit
`timescale 1ns/10ps
module lco_exec_checker
  import lco_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        start,
  input wire lco_op_t     op,
  input wire lco_form_t   form,
  input wire lco_dst_t    dst,
  input wire logic [15:0] src_val,
  input wire logic [15:0] reg_val,
  input wire logic [35:0] acc_val,
  input wire logic [5:0]  short_addr,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        refused,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        mem_io,
  input wire logic [15:0] mem_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        acc_wr,
  input wire logic [35:0] acc_wdata,
  input wire logic [15:0] sr_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Accepted requests, split by the length of the form
  wire take  = start && !busy;
  wire hardware_stack   = dst == LCO_DST_HWS && form == LCO_FORM_REG;
  wire bf    = take && op != LCO_OP_REG_OR && !hardware_stack;
  wire quick = form == LCO_FORM_REG || form == LCO_FORM_SHORT
               || form == LCO_FORM_IO;

  // Read, one wait cycle, then the single write-back
  sequence rmw_s;
    mem_rd && !mem_wr ##1 !mem_wr ##1 mem_wr && done;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  chk_or_two_cycles: assert property (
    take && op == LCO_OP_REG_OR |=> done)
    else $error("register OR did not finish in two cycles");
  chk_short_count: assert property (
    bf && quick |=> !done [*2] ##1 done)
    else $error("short form cycle count wrong");
  chk_long_count: assert property (
    bf && !quick |=> !done [*4] ##1 done)
    else $error("long form cycle count wrong");
  chk_hws_refused: assert property (
    take && op != LCO_OP_REG_OR && hardware_stack |-> refused ##1 !busy)
    else $error("hardware stack destination accepted");
  chk_short_addr: assert property (
    bf && form == LCO_FORM_SHORT |=> mem_rd && !mem_io
    && mem_addr == {10'h000, $past(short_addr)})
    else $error("short direct address wrong");
  chk_io_addr: assert property (
    bf && form == LCO_FORM_IO |=> mem_rd && mem_io
    && mem_addr == (IO_BASE | {10'h000, $past(short_addr)}))
    else $error("short I/O address wrong");
  chk_rmw_pair: assert property (
    bf && form == LCO_FORM_SHORT |=> rmw_s)
    else $error("read-modify-write order wrong");
  chk_or_acc_mid: assert property (
    take && op == LCO_OP_REG_OR && dst == LCO_DST_ACC
    |=> acc_wr && acc_wdata == {$past(acc_val[35:32]),
    $past(acc_val[31:16]) | $past(src_val), $past(acc_val[15:0])}
    && !sr_wdata[CC_V] && sr_wdata[CC_N] == acc_wdata[31]
    && sr_wdata[CC_Z] == (acc_wdata[31:16] == 16'h0000))
    else $error("register OR to accumulator wrong");
  chk_compl_reg: assert property (
    bf && op == LCO_OP_COMPL_CARRY && dst == LCO_DST_REG16
    && form == LCO_FORM_REG |-> ##3 reg_wr
    && reg_wdata == ~$past(reg_val, 3)
    && sr_wdata[CC_C] == ($past(reg_val, 3) == 16'hffff))
    else $error("register complement or carry wrong");
endmodule // lco_exec_checker

bind lco_exec lco_exec_checker u_lco_exec_checker (.*);

/* File: verification/lco_mem_model.sv */
// Behavioural X data memory facing the execution unit
`timescale 1ns/10ps
module lco_mem_model
(
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] store [64];

  // Blank store; low six address bits only, so I/O aliases short direct
  initial
  begin
    mem_rdata = 16'h0000;
    foreach (store[i]) store[i] = 16'h0000;
  end

  // Data valid one cycle after a read, flipped otherwise so stale data shows
  always @(posedge clk)
  begin
    if (mem_rd) mem_rdata <= store[mem_addr[5:0]];
    else mem_rdata <= ~mem_rdata;
    if (mem_wr) store[mem_addr[5:0]] <= mem_wdata;
  end
endmodule // lco_mem_model

/* File: verification/testbench.sv */
// Self-checking bench for the complement/OR execution unit
`timescale 1ns/10ps
module testbench import lco_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0;
  lco_op_t     op = LCO_OP_COMPL_CARRY;
  lco_form_t   form = LCO_FORM_REG;
  lco_dst_t    dst = LCO_DST_REG16;
  logic [15:0] imm = 16'h0000, src_val = 16'h0000, reg_val = 16'h0000;
  logic [15:0] sr_val = 16'h0000, addr_reg_two = 16'h0010;
  logic [15:0] stack_pointer = 16'h0030, long_addr = 16'h0021;
  logic [35:0] acc_val = 36'h0;
  logic [5:0]  short_addr = 6'h00, offset = 6'h03;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, reg_wdata, sr_wdata;
  logic [35:0] acc_wdata;
  logic [1:0]  instr_words;
  logic        busy, done, refused, mem_rd, mem_wr, mem_io;
  logic        reg_wr, acc_wr, sr_wr;
  int          fail_count = 0, num_checks = 0, cyc;

  lco_exec u_lco_exec (.*);
  lco_mem_model u_lco_mem_model (.*);

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(string name, logic [35:0] exp, logic [35:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One idle edge first, so start never lands in a busy cycle
  task automatic run(lco_op_t o, lco_form_t f, lco_dst_t d, logic [15:0] m);
    @(posedge clk);
    #1 op = o;
    form = f;
    dst = d;
    imm = m;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    cyc = 2;
    while (done !== 1'b1 && cyc < 12)
    begin
      @(posedge clk);
      #1 cyc++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_compl_reg();
    sr_val = 16'h0308;
    reg_val = 16'hcaa3;
    run(LCO_OP_COMPL_CARRY, LCO_FORM_REG, LCO_DST_REG16, 16'h0000);
    check("reg", 36'h0355c, 36'(reg_wdata));
    check("sr", 36'h0308, 36'(sr_wdata));
    check("sr_wr", 36'h1, 36'(sr_wr));
    sr_val = 16'h0300;
    reg_val = 16'hffff;
    run(LCO_OP_COMPL_CARRY, LCO_FORM_REG, LCO_DST_REG16, 16'h0000);
    check("reg", 36'h0, 36'(reg_wdata));
    check("sr", 36'h0301, 36'(sr_wdata));
    acc_val = 36'h512345678;
    run(LCO_OP_COMPL_CARRY, LCO_FORM_REG, LCO_DST_ACC, 16'h0000);
    check("acc", 36'h5edcb5678, acc_wdata);
  endtask

  task automatic t_status();
    sr_val = 16'h0300;
    run(LCO_OP_COMPL_CARRY, LCO_FORM_REG, LCO_DST_STATUS, 16'h0000);
    check("sr", 36'h0fcff, 36'(sr_wdata));
    run(LCO_OP_IMM_SET, LCO_FORM_REG, LCO_DST_STATUS, 16'h0005);
    check("sr", 36'h0305, 36'(sr_wdata));
    check("sr_wr", 36'h1, 36'(sr_wr));
  endtask

  task automatic t_hws();
    lco_op_t ol [2] = '{LCO_OP_COMPL_CARRY, LCO_OP_IMM_SET};
    foreach (ol[i])
    begin
      @(posedge clk);
      #1 op = ol[i];
      form = LCO_FORM_REG;
      dst = LCO_DST_HWS;
      start = 1'b1;
      #1 check("refused", 36'h1, 36'(refused));
      @(posedge clk);
      #1 start = 1'b0;
      check("busy", 36'h0, 36'(busy));
    end
  endtask

  task automatic t_mem();
    sr_val = 16'h0300;
    short_addr = 6'h30;
    u_lco_mem_model.store[6'h30] = 16'h00aa;
    run(LCO_OP_IMM_SET, LCO_FORM_SHORT, LCO_DST_REG16, 16'h5050);
    check("wdata", 36'h050fa, 36'(mem_wdata));
    check("sr", 36'h0300, 36'(sr_wdata));
    run(LCO_OP_IMM_SET, LCO_FORM_SHORT, LCO_DST_REG16, 16'h5050);
    check("sr", 36'h0301, 36'(sr_wdata));
    run(LCO_OP_BF_SET, LCO_FORM_SHORT, LCO_DST_REG16, 16'h0f00);
    check("wdata", 36'h05ffa, 36'(mem_wdata));
    short_addr = 6'h05;
    u_lco_mem_model.store[6'h05] = 16'hffff;
    run(LCO_OP_BF_CHANGE, LCO_FORM_IO, LCO_DST_REG16, 16'hffff);
    check("wdata", 36'h0, 36'(mem_wdata));
    check("sr", 36'h0301, 36'(sr_wdata));
    check("mem_io", 36'h1, 36'(mem_io));
  endtask

  task automatic t_forms();
    lco_form_t fl [6] = '{LCO_FORM_REG, LCO_FORM_R2_OFF, LCO_FORM_SP_OFF,
                          LCO_FORM_SHORT, LCO_FORM_IO, LCO_FORM_LONG};
    int        cl [6] = '{4, 6, 6, 4, 4, 6};
    int        wl [6] = '{2, 2, 2, 2, 2, 3};
    lco_op_t   ol [2] = '{LCO_OP_COMPL_CARRY, LCO_OP_IMM_SET};
    foreach (ol[j])
      for (int i = 0; i < 6; i++)
      begin
        run(ol[j], fl[i], LCO_DST_REG16, 16'h8001);
        check("cycles", 36'(cl[i]), 36'(cyc));
        check("words", 36'(wl[i]), 36'(instr_words));
      end
  endtask

  task automatic t_or();
    src_val = 16'hff00;
    acc_val = 36'h012345678;
    sr_val = 16'h0301;
    run(LCO_OP_REG_OR, LCO_FORM_REG, LCO_DST_ACC, 16'h0000);
    check("acc", 36'h0ff345678, acc_wdata);
    check("sr", 36'h0309, 36'(sr_wdata));
    check("cycles", 36'h2, 36'(cyc));
    check("words", 36'h1, 36'(instr_words));
    src_val = 16'h0000;
    acc_val = 36'hf00001234;
    sr_val = 16'h0303;
    run(LCO_OP_REG_OR, LCO_FORM_REG, LCO_DST_ACC, 16'h0000);
    check("acc", 36'hf00001234, acc_wdata);
    check("sr", 36'h0305, 36'(sr_wdata));
  endtask

  // Watchdog, far beyond the roughly 110 cycles the scenarios need
  initial
  begin
    #100000;
    fail_count++;
    $display("MISMATCH watchdog expected finish seen hang");
    wrap_up();
  end

  // Reset for four cycles, then every scenario in turn
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_compl_reg();
    t_status();
    t_hws();
    t_mem();
    t_forms();
    t_or();
    wrap_up();
  end
endmodule // testbench
